// File: rtl/spp_pkg.sv
package spp_pkg;
	localparam int SYS_CLK_MHZ = 50;
	// internal power-on reset limit, in microseconds
	localparam int POR_MAX_US = 100;
	localparam int POR_CYCLES = POR_MAX_US * SYS_CLK_MHZ;
	// reset low to pin float, in system clocks (least 1, most 2)
	localparam int RESET_LOW_TO_FLOAT_CYC = 1;
	localparam int BYTE_BITS = 8;
	localparam logic [2:0] BIT_CNT_RESET = 3'h0;
	localparam logic [7:0] TX_RESET = 8'h00;
	typedef enum logic [1:0] {
		SPP_POR,
		SPP_RUN,
		SPP_PROG
	} spp_state_t;
endpackage

// File: rtl/spp_shift.sv
module spp_shift
	import spp_pkg::*;
#(
	parameter int WIDTH = BYTE_BITS
) (
	input wire logic reset_n_i,
	input wire logic sck_i,
	input wire logic sel_n_i,
	input wire logic mosi_i,
	input wire logic [WIDTH-1:0] tx_data_i,
	output logic miso_o,
	output logic rx_toggle_o,
	output logic [WIDTH-1:0] rx_data_o
);
	// clock of this domain stops between frames; slave select ends each frame
	logic [WIDTH-1:0] shift_in;
	logic [WIDTH-1:0] shift_out;
	logic [$clog2(WIDTH)-1:0] bit_cnt;
	logic [WIDTH-1:0] next_in;
	logic last_bit;
	localparam int CNT_W = $clog2(WIDTH);
	localparam logic [CNT_W-1:0] FIRST_SHIFT = CNT_W'(1);

	assign next_in = {shift_in[WIDTH-2:0], mosi_i};
	assign last_bit = (bit_cnt == WIDTH[$clog2(WIDTH)-1:0] - 1'b1);

	// sample on rising edge, msb first; select high drops a partial byte
	always_ff @(posedge sck_i or posedge sel_n_i) begin
		if (sel_n_i) begin
			shift_in <= '0;
			bit_cnt <= '0;
		end else begin
			shift_in <= next_in;
			bit_cnt <= bit_cnt + 1'b1;
		end
	end

	// toggle keeps its level across frames: clearing it on select would read as a new byte
	always_ff @(posedge sck_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_toggle_o <= 1'b0;
			rx_data_o <= '0;
		end else if (last_bit) begin
			rx_data_o <= next_in;
			rx_toggle_o <= ~rx_toggle_o;
		end
	end

	// msb comes from the mux; the rest of the word loads at the first falling edge
	always_ff @(negedge sck_i or posedge sel_n_i) begin
		if (sel_n_i) begin
			shift_out <= '0;
		end else if (bit_cnt == FIRST_SHIFT) begin
			shift_out <= {tx_data_i[WIDTH-2:0], 1'b0};
		end else begin
			shift_out <= {shift_out[WIDTH-2:0], 1'b0};
		end
	end

	assign miso_o = (bit_cnt == '0 && !sck_i) ? tx_data_i[WIDTH-1] : shift_out[WIDTH-1];
endmodule

// File: rtl/spp_port.sv
// Behaviour
// - reset pin as io or fuse off: entry only at power-up
// - io pins float one to two system clocks after reset low; here three, via the two-stage sync and the float flop
// - programmer is spi master, device is spi slave
// - mosi in, miso out, bytes full duplex, msb first
// - spi mode 0: sample rising edge, change on falling edge
// - session-dependent fuse changes apply when reset returns high
module spp_port
	import spp_pkg::*;
#(
	parameter int POR_CYC = POR_CYCLES,
	parameter int WIDTH = BYTE_BITS
) (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic sck_i,
	input wire logic rst_pin_n_i,
	input wire logic sel_n_i,
	input wire logic mosi_i,
	input wire logic reset_pin_is_io_i,
	input wire logic prog_fuse_off_i,
	input wire logic [1:0] pend_fuse_i,
	input wire logic pend_fuse_wr_i,
	input wire logic [WIDTH-1:0] tx_data_i,
	output logic miso_o,
	output logic miso_oe_o,
	output logic io_float_o,
	output logic por_busy_o,
	output logic serial_program_mode_o,
	output logic rx_valid_o,
	output logic [WIDTH-1:0] rx_data_o,
	output logic [1:0] fuse_active_o
);
	spp_state_t state;
	spp_state_t next_state;
	logic [$clog2(POR_CYC+1)-1:0] por_cnt;
	logic [1:0] rst_sync;
	logic miso_meta;
	logic [1:0] sel_sync;
	logic [2:0] tog_sync;
	logic rst_low;
	logic sel_low;
	logic entry_ok;
	logic [1:0] pend_fuse;
	logic [WIDTH-1:0] tx_hold;
	logic link_miso;
	logic link_toggle;
	logic [WIDTH-1:0] link_data;
	logic rx_event;
	logic por_done;
	logic session_end;

	spp_shift #(.WIDTH(WIDTH)) u_shift (
		.reset_n_i(reset_n_i),
		.sck_i(sck_i),
		.sel_n_i(sel_n_i),
		.mosi_i(mosi_i),
		.tx_data_i(tx_hold),
		.miso_o(link_miso),
		.rx_toggle_o(link_toggle),
		.rx_data_o(link_data)
	);

	assign rst_low = !rst_sync[1];
	assign sel_low = !sel_sync[1];
	assign rx_event = tog_sync[2] ^ tog_sync[1];
	assign por_done = (por_cnt == POR_CYC[$bits(por_cnt)-1:0]);
	// with reset as io or fuse off, only a power-up entry is taken
	assign entry_ok = !reset_pin_is_io_i && !prog_fuse_off_i;
	assign session_end = (state == SPP_PROG) && !rst_low;

	always_comb begin
		next_state = state;
		case (state)
			SPP_POR: begin
				// programmer holds reset low through power-up and enters directly
				if (por_done) begin
					next_state = rst_low ? SPP_PROG : SPP_RUN;
				end
			end
			SPP_RUN: begin
				if (rst_low && entry_ok) begin
					next_state = SPP_PROG;
				end
			end
			SPP_PROG: begin
				if (!rst_low) begin
					next_state = SPP_RUN;
				end
			end
			default: next_state = SPP_POR;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_sync <= 2'h0;
			sel_sync <= 2'h3;
			tog_sync <= 3'h0;
		end else begin
			rst_sync <= {rst_sync[0], rst_pin_n_i};
			sel_sync <= {sel_sync[0], sel_n_i};
			tog_sync <= {tog_sync[1:0], link_toggle};
		end
	end

	// power-on reset counter bounds the startup to the limit
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			por_cnt <= '0;
		end else if (!por_done) begin
			por_cnt <= por_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= SPP_POR;
			por_busy_o <= 1'b1;
			serial_program_mode_o <= 1'b0;
		end else begin
			state <= next_state;
			por_busy_o <= !por_done;
			serial_program_mode_o <= (next_state == SPP_PROG);
		end
	end

	// the two-stage sync plus this flop gives three clocks from pin edge
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			io_float_o <= 1'b1;
		end else begin
			io_float_o <= rst_low || (state == SPP_POR);
		end
	end

	// miso drives only in session with select low
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			miso_oe_o <= 1'b0;
			miso_meta <= 1'b0;
			miso_o <= 1'b0;
		end else begin
			miso_oe_o <= (state == SPP_PROG) && sel_low;
			// serial out comes from the link clock: two flops, costs up to 40 ns of the low phase
			miso_meta <= link_miso;
			miso_o <= miso_meta;
		end
	end

	// tx word is sampled by the link only while stable between bytes
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tx_hold <= TX_RESET;
		end else if (sel_sync[1] || rx_event) begin
			tx_hold <= tx_data_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_valid_o <= 1'b0;
			rx_data_o <= '0;
		end else begin
			rx_valid_o <= rx_event && (next_state == SPP_PROG);
			if (rx_event) begin
				rx_data_o <= link_data;
			end
		end
	end

	// session fuses staged, applied when reset returns high
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pend_fuse <= 2'h3;
			fuse_active_o <= 2'h3;
		end else begin
			if (pend_fuse_wr_i) begin
				pend_fuse <= pend_fuse_i;
			end
			if (session_end) begin
				fuse_active_o <= pend_fuse_wr_i ? pend_fuse_i : pend_fuse;
			end
		end
	end
endmodule

// File: tb/spp_port_assertions.sv
module spp_port_assertions #(
	parameter int POR_CYC = 20
) (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic rst_pin_n_i,
	input wire logic sel_n_i,
	input wire logic reset_pin_is_io_i,
	input wire logic prog_fuse_off_i,
	input wire logic miso_oe_o,
	input wire logic io_float_o,
	input wire logic por_busy_o,
	input wire logic serial_program_mode_o,
	input wire logic rx_valid_o,
	input wire logic [1:0] fuse_active_o
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int POR_LIM = POR_CYC + 3;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	AST_POR_HOLD: assert property ($rose(reset_n_i) |-> por_busy_o [*8])
		else $error("por short");
	AST_POR_END: assert property ($rose(reset_n_i) |-> ##[1:POR_LIM] !por_busy_o)
		else $error("por long");
	AST_FLOAT_SOON: assert property ($fell(rst_pin_n_i) |-> ##[1:3] io_float_o)
		else $error("float late");
	AST_FLOAT_HOLD: assert property (!rst_pin_n_i [*4] |-> io_float_o)
		else $error("float lost");
	AST_NO_ENTRY: assert property ((reset_pin_is_io_i || prog_fuse_off_i) && !por_busy_o
		&& !$past(por_busy_o) && !serial_program_mode_o |=> !serial_program_mode_o)
		else $error("entry taken");
	AST_OE_OFF: assert property (sel_n_i [*4] |-> !miso_oe_o)
		else $error("oe on");
	AST_RX_MODE: assert property (rx_valid_o |-> serial_program_mode_o)
		else $error("rx outside mode");
	AST_RX_PULSE: assert property (rx_valid_o |=> !rx_valid_o)
		else $error("rx long");
	AST_FUSE_HOLD: assert property (serial_program_mode_o && $past(serial_program_mode_o)
		|-> $stable(fuse_active_o)) else $error("fuse early");
endmodule

// File: tb/spp_prog_model.sv
module spp_prog_model (
	output logic sck_o,
	output logic sel_n_o,
	output logic mosi_o,
	output logic rst_pin_n_o,
	input wire logic miso_i,
	input wire logic miso_oe_i
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{sck_o, sel_n_o, mosi_o, rst_pin_n_o} = 4'h4;
	end
	// master, mode 0, msb first, 240 ns period
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		sel_n_o = 1'b0;
		#150;
		for (int i = 7; i >= 0; i--) begin
			mosi_o = tx[i];
			#120 sck_o = 1'b1;
			// late sample: miso is resynced to the system clock
			rx = {rx[6:0], miso_oe_i ? miso_i : 1'bz};
			#120 sck_o = 1'b0;
		end
		#100 sel_n_o = 1'b1;
		mosi_o = ~mosi_o;
		#100;
	endtask
	// shortest waits after write, write with erase and chip erase, in ns
	// not used by the short run: each one exceeds the cycle budget of the bench
	localparam int WRITE_WAIT_NS = 2500000;
	localparam int ERASE_WRITE_WAIT_NS = 5000000;
	localparam int CHIP_ERASE_WAIT_NS = 7500000;
	task automatic op_wait(input logic [1:0] kind);
		case (kind)
			2'h0: #(WRITE_WAIT_NS);
			2'h1: #(ERASE_WRITE_WAIT_NS);
			default: #(CHIP_ERASE_WAIT_NS);
		endcase
	endtask
endmodule

// File: tb/spp_port_tb.sv
module spp_port_tb
	import spp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i, reset_n_i, io_cfg, fuse_off, pend_wr, miso, oe, io_float, por_busy, mode, rxv;
	logic sck, sel_n, mosi, rst_pin;
	logic [1:0] pend_fuse, fuse_act;
	logic [7:0] tx_data, rx_data, got, rx;
	int error_cnt = 0;
	int num_checks = 0;
	int n_rx = 0;
	spp_prog_model i_prog (.sck_o(sck), .sel_n_o(sel_n), .mosi_o(mosi), .rst_pin_n_o(rst_pin),
		.miso_i(miso), .miso_oe_i(oe));
	spp_port #(.POR_CYC(20)) i_dut (.clk_sys_i, .reset_n_i, .sck_i(sck), .rst_pin_n_i(rst_pin),
		.sel_n_i(sel_n), .mosi_i(mosi), .reset_pin_is_io_i(io_cfg), .prog_fuse_off_i(fuse_off),
		.pend_fuse_i(pend_fuse), .pend_fuse_wr_i(pend_wr), .tx_data_i(tx_data), .miso_o(miso),
		.miso_oe_o(oe), .io_float_o(io_float), .por_busy_o(por_busy),
		.serial_program_mode_o(mode), .rx_valid_o(rxv), .rx_data_o(rx_data), .fuse_active_o(fuse_act));
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) if (rxv === 1'b1) begin
		got <= rx_data;
		n_rx <= n_rx + 1;
	end
	function automatic logic [7:0] host_byte(input logic [7:0] b);
		return b ^ 8'h5A;
	endfunction
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic summarize;
		if (error_cnt == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic byte_io(input logic [7:0] b, input bit live);
		int k;
		k = n_rx;
		tx_data = b;
		i_prog.xfer(host_byte(b), rx);
		step(2);
		if (live) begin
			chk(rx, b);
			chk(got, host_byte(b));
			chk(8'(n_rx - k), 8'h01);
		end else begin
			chk(rx, 8'hZZ);
			chk(8'(n_rx - k), 8'h00);
		end
	endtask
	initial begin
		void'($urandom(32'h5A53595C));
		{reset_n_i, io_cfg, fuse_off, pend_wr, pend_fuse, tx_data} = {4'h6, 2'h0, TX_RESET};
		step(5);
		reset_n_i = 1'b1;
		chk(8'({por_busy, fuse_act}), 8'h07);
		step(25);
		chk(8'({mode, io_float}), 8'h03);
		byte_io(8'h80, 1'b1);
		byte_io(8'h01, 1'b1);
		repeat (6) byte_io(8'($urandom), 1'b1);
		pend_fuse = {1'b0, 1'($urandom)};
		pend_wr = 1'b1;
		step(1);
		pend_wr = 1'b0;
		step(3);
		chk(8'(fuse_act), 8'h03);
		i_prog.rst_pin_n_o = 1'b1;
		step(8);
		chk(8'(fuse_act), 8'(pend_fuse));
		chk(8'({mode, io_float, oe}), 8'h00);
		i_prog.rst_pin_n_o = 1'b0;
		step(10);
		chk(8'({mode, io_float}), 8'h01);
		byte_io(8'($urandom), 1'b0);
		i_prog.rst_pin_n_o = 1'b1;
		step(4);
		chk(8'(mode), 8'h00);
		{io_cfg, fuse_off} = 2'h0;
		i_prog.rst_pin_n_o = 1'b0;
		step(3);
		chk(8'(io_float), 8'h01);
		step(5);
		chk(8'(mode), 8'h01);
		byte_io(8'($urandom), 1'b1);
		summarize();
	end
	initial begin
		#200000;
		error_cnt++;
		summarize();
	end
endmodule
bind spp_port spp_port_assertions #(.POR_CYC(POR_CYC)) i_chk (.*);
